// ===== rtl/gpc_pkg.sv
package gpc_pkg;

    // ------------------------------------------------------------
    // Port geometry
    // ------------------------------------------------------------
    localparam int unsigned PORT_W = 16;      // Pins in one port
    localparam int unsigned SYNC_STAGES = 3;  // Pin sampling depth

    // ------------------------------------------------------------
    // Register map: base index in adr[7:4], alias in adr[3:2]
    // ------------------------------------------------------------
    localparam logic [3:0] REG_ANALOG = 4'h0;      // analog_select
    localparam logic [3:0] REG_DIR = 4'h1;         // direction_select
    localparam logic [3:0] REG_PIN = 4'h2;         // pin_level
    localparam logic [3:0] REG_LATCH = 4'h3;       // output_latch
    localparam logic [3:0] REG_OPEN_DRAIN = 4'h4;  // open_drain_select
    localparam logic [3:0] REG_NOTICE_CTRL = 4'h5; // change_notice_control
    localparam logic [3:0] REG_EN_LOW = 4'h6;      // change_enable_low
    localparam logic [3:0] REG_STATUS = 4'h7;      // change_status
    localparam logic [3:0] REG_EN_HIGH = 4'h8;     // change_enable_high
    localparam logic [3:0] REG_FLAGS = 4'h9;       // change_event_flags

    // Alias operations selected by adr[3:2]
    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_CLR = 2'h1;
    localparam logic [1:0] OP_SET = 2'h2;
    localparam logic [1:0] OP_INV = 2'h3;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned ON_BIT = 15;
    localparam int unsigned STYLE_BIT = 11;
    localparam logic [15:0] NOTICE_CTRL_MASK = 16'h8800; // Writable bits
    localparam logic [15:0] ANALOG_RST = 16'hffff;
    localparam logic [15:0] DIR_RST = 16'hffff;
    localparam logic [15:0] ZERO_RST = 16'h0000;

    // Apply a write or an atomic alias op to a base register
    function automatic logic [15:0] gpc_apply(input logic [15:0] old,
                                              input logic [15:0] wd,
                                              input logic [15:0] m,
                                              input logic [1:0] op);
        logic [15:0] v;
        v = wd & m;
        case (op)
            OP_CLR: gpc_apply = old & ~v;
            OP_SET: gpc_apply = old | v;
            OP_INV: gpc_apply = old ^ v;
            default: gpc_apply = (old & ~m) | v;
        endcase
    endfunction

endpackage

// ===== rtl/gpc_notice_if.sv
// Carries port state to the change detector and its events back
interface gpc_notice_if;
    import gpc_pkg::*;
    logic [PORT_W-1:0] pin;       // Synchronised pin levels
    logic [PORT_W-1:0] last_read; // Levels seen at last pin_level read
    logic [PORT_W-1:0] dir;       // Direction, one = input
    logic [PORT_W-1:0] en_low;    // change_enable_low
    logic [PORT_W-1:0] en_high;   // change_enable_high
    logic on;                     // Module on
    logic style;                  // edge_style_select
    logic [PORT_W-1:0] evt;       // Change events: one-cycle edges, or held mismatch in style zero
    modport ctrl(output pin, last_read, dir, en_low, en_high, on, style, input evt);
    modport det(input pin, last_read, dir, en_low, en_high, on, style, output evt);
endinterface

// ===== rtl/gpc_pin_sync.sv
module gpc_pin_sync
    import gpc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [PORT_W-1:0] pad_in_i,
    output logic [PORT_W-1:0] pin_o
);

    // ------------------------------------------------------------
    // Three-deep sampling chain
    // ------------------------------------------------------------
    logic [PORT_W-1:0] stage_q [SYNC_STAGES]; // Stage 0 feeds only stage 1

    // Shift pins through the chain; read back three clocks late
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < SYNC_STAGES; i++) begin
                stage_q[i] <= ZERO_RST;
            end
        end else begin
            stage_q[0] <= pad_in_i;
            for (int i = 1; i < SYNC_STAGES; i++) begin
                stage_q[i] <= stage_q[i-1];
            end
        end
    end

    assign pin_o = stage_q[SYNC_STAGES-1];

endmodule

// ===== rtl/gpc_change_detect.sv
module gpc_change_detect
    import gpc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    gpc_notice_if.det chg
);

    // ------------------------------------------------------------
    // Edge and mismatch detection
    // ------------------------------------------------------------
    logic [PORT_W-1:0] prev_q; // Pin levels one clock earlier
    wire [PORT_W-1:0] rise_w = chg.pin & ~prev_q;
    wire [PORT_W-1:0] fall_w = ~chg.pin & prev_q;
    wire [PORT_W-1:0] mism_w = chg.pin ^ chg.last_read;
    // Style one picks edges per enable pair; style zero uses mismatch
    wire [PORT_W-1:0] edge_w = (chg.en_low & rise_w) | (chg.en_high & fall_w);
    wire [PORT_W-1:0] sel_w = chg.style ? edge_w : (chg.en_low & mism_w);
    // No clock gate is involved, so detection keeps working in sleep
    assign chg.evt = chg.on ? (sel_w & chg.dir) : ZERO_RST;

    // Remember the previous sample for edge detection
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prev_q <= ZERO_RST;
        end else begin
            prev_q <= chg.pin;
        end
    end

endmodule

// ===== rtl/gpc_port_top.sv
// Summary of operation
// - Alias writes clear, set or invert one-bits
// - Alias addresses read back as zero
// - Direction one means input, zero output
// - Reset sets every direction bit
// - Latch drives outputs; pin writes hit latch
// - Pin reads are three clocks late
// - Open-drain bit makes output drive low only
// - Analog input pins read as zero
// - Analog select resets to all ones
// - Output level on analog pins reaches analog side
// - Change detection needs no gated clock
// - Each pin has its own enable pair
// - Detection runs only with module on
// - Enables plus style choose transition type
// - Five change notice registers per port
// - Ten base registers, forty addresses including aliases
// - Style zero mismatch; style one edge choices
// - Status shows change since last pin read
// - Flags stick until software clears them
// - Only input pins raise change events
module gpc_port_top
    import gpc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [PORT_W-1:0] pad_in_i,
    output logic [PORT_W-1:0] pad_out_o,
    output logic [PORT_W-1:0] pad_oe_o,
    output logic [PORT_W-1:0] analog_drive_o,
    output logic notice_irq_o
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [PORT_W-1:0] ansel_q;   // analog_select
    logic [PORT_W-1:0] dir_q;     // direction_select
    logic [PORT_W-1:0] lat_q;     // output_latch
    logic [PORT_W-1:0] odc_q;     // open_drain_select
    logic [PORT_W-1:0] ctrl_q;    // change_notice_control
    logic [PORT_W-1:0] en_low_q;  // change_enable_low
    logic [PORT_W-1:0] en_high_q; // change_enable_high
    logic [PORT_W-1:0] flags_q;   // change_event_flags
    logic [PORT_W-1:0] last_q;    // Pins seen at last pin_level read
    logic ack_q;                  // Bus answer
    logic [31:0] rdat_q;          // Bus read data
    logic [PORT_W-1:0] out_q;     // Pad drive level
    logic [PORT_W-1:0] oe_q;      // Pad drive enable
    logic [PORT_W-1:0] adrv_q;    // Level offered to analog side
    logic irq_q;                  // Change notice request

    // ------------------------------------------------------------
    // Pin sampling and change detection
    // ------------------------------------------------------------
    logic [PORT_W-1:0] pin_w; // Synchronised pins
    gpc_notice_if chg();

    gpc_pin_sync u_sync (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .pad_in_i(pad_in_i),
        .pin_o(pin_w)
    );

    gpc_change_detect u_detect (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .chg(chg.det)
    );

    // Feed the detector with the live configuration
    assign chg.pin = pin_w;
    assign chg.last_read = last_q;
    assign chg.dir = dir_q;
    assign chg.en_low = en_low_q;
    assign chg.en_high = en_high_q;
    assign chg.on = ctrl_q[ON_BIT];
    assign chg.style = ctrl_q[STYLE_BIT];

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Answer takes one idle clock, so ack is one cycle after the request
    wire acc_w = wb_cyc_i & wb_stb_i & ~ack_q;
    wire wr_w = acc_w & wb_we_i;
    wire rd_w = acc_w & ~wb_we_i;
    wire [3:0] base_w = wb_adr_i[7:4];
    wire [1:0] op_w = wb_adr_i[3:2];
    wire [15:0] wd_w = wb_dat_i[15:0];
    // Only the two low byte lanes hold data
    wire [15:0] m_w = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Base register hit strobes, every alias included
    wire wr_ansel_w = wr_w & (base_w == REG_ANALOG);
    wire wr_dir_w = wr_w & (base_w == REG_DIR);
    // Pin and latch addresses both land in the latch
    wire wr_lat_w = wr_w & ((base_w == REG_PIN) | (base_w == REG_LATCH));
    wire wr_odc_w = wr_w & (base_w == REG_OPEN_DRAIN);
    wire wr_ctrl_w = wr_w & (base_w == REG_NOTICE_CTRL);
    wire wr_enl_w = wr_w & (base_w == REG_EN_LOW);
    wire wr_enh_w = wr_w & (base_w == REG_EN_HIGH);
    wire wr_flags_w = wr_w & (base_w == REG_FLAGS);
    // Pin read at its base address refreshes the mismatch reference
    wire rd_pin_w = rd_w & (base_w == REG_PIN) & (op_w == OP_WRITE);

    // ------------------------------------------------------------
    // Next register values
    // ------------------------------------------------------------
    wire [15:0] ansel_d = gpc_apply(ansel_q, wd_w, m_w, op_w);
    wire [15:0] dir_d = gpc_apply(dir_q, wd_w, m_w, op_w);
    wire [15:0] lat_d = gpc_apply(lat_q, wd_w, m_w, op_w);
    wire [15:0] odc_d = gpc_apply(odc_q, wd_w, m_w, op_w);
    wire [15:0] ctrl_d = gpc_apply(ctrl_q, wd_w, m_w & NOTICE_CTRL_MASK, op_w);
    wire [15:0] enl_d = gpc_apply(en_low_q, wd_w, m_w, op_w);
    wire [15:0] enh_d = gpc_apply(en_high_q, wd_w, m_w, op_w);
    // New events win over a clearing write in the same clock
    wire [15:0] flags_base_w = wr_flags_w ? gpc_apply(flags_q, wd_w, m_w, op_w) : flags_q;
    wire [15:0] flags_d = flags_base_w | chg.evt;
    // Enabled input flags collapse into one request
    wire [15:0] live_w = flags_q & dir_q & (en_low_q | en_high_q);
    wire irq_d = ctrl_q[ON_BIT] & (|live_w);

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Analog input pins are masked off the pin image
    wire [15:0] pin_img_w = pin_w & ~(ansel_q & dir_q);
    // Status compares live pins with the last read reference
    wire [15:0] status_w = pin_w ^ last_q;
    logic [15:0] rd_word;

    // Base addresses only; aliases and holes read as zero
    always_comb begin
        rd_word = ZERO_RST;
        if (op_w != OP_WRITE) begin
            rd_word = ZERO_RST;
        end else if (base_w == REG_ANALOG) begin
            rd_word = ansel_q;
        end else if (base_w == REG_DIR) begin
            rd_word = dir_q;
        end else if (base_w == REG_PIN) begin
            rd_word = pin_img_w;
        end else if (base_w == REG_LATCH) begin
            rd_word = lat_q;
        end else if (base_w == REG_OPEN_DRAIN) begin
            rd_word = odc_q;
        end else if (base_w == REG_NOTICE_CTRL) begin
            rd_word = ctrl_q;
        end else if (base_w == REG_EN_LOW) begin
            rd_word = en_low_q;
        end else if (base_w == REG_STATUS) begin
            rd_word = status_w;
        end else if (base_w == REG_EN_HIGH) begin
            rd_word = en_high_q;
        end else if (base_w == REG_FLAGS) begin
            rd_word = flags_q;
        end
    end

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------
    // Ack for one clock; data stands until the next read
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= acc_w;
            if (rd_w) begin
                rdat_q <= {16'h0000, rd_word};
            end
        end
    end

    // ------------------------------------------------------------
    // Port configuration registers
    // ------------------------------------------------------------
    // Directions and analog selects start as analog inputs
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ansel_q <= ANALOG_RST;
            dir_q <= DIR_RST;
            odc_q <= ZERO_RST;
        end else begin
            if (wr_ansel_w) begin
                ansel_q <= ansel_d;
            end
            if (wr_dir_w) begin
                dir_q <= dir_d;
            end
            if (wr_odc_w) begin
                odc_q <= odc_d;
            end
        end
    end

    // Output latch, shared by pin and latch addresses
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lat_q <= ZERO_RST;
        end else if (wr_lat_w) begin
            lat_q <= lat_d;
        end
    end

    // ------------------------------------------------------------
    // Change notice registers
    // ------------------------------------------------------------
    // Control and enable pairs
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ctrl_q <= ZERO_RST;
            en_low_q <= ZERO_RST;
            en_high_q <= ZERO_RST;
        end else begin
            if (wr_ctrl_w) begin
                ctrl_q <= ctrl_d;
            end
            if (wr_enl_w) begin
                en_low_q <= enl_d;
            end
            if (wr_enh_w) begin
                en_high_q <= enh_d;
            end
        end
    end

    // Sticky flags, mismatch reference and request
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flags_q <= ZERO_RST;
            last_q <= ZERO_RST;
            irq_q <= 1'b0;
        end else begin
            flags_q <= flags_d;
            if (rd_pin_w) begin
                last_q <= pin_w;
            end
            irq_q <= irq_d;
        end
    end

    // ------------------------------------------------------------
    // Pad drive
    // ------------------------------------------------------------
    // Open-drain pins only pull low; a high latch releases the pad
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            out_q <= ZERO_RST;
            oe_q <= ZERO_RST;
            adrv_q <= ZERO_RST;
        end else begin
            out_q <= lat_q & ~odc_q;
            oe_q <= ~dir_q & ~(odc_q & lat_q);
            adrv_q <= lat_q & ~dir_q & ansel_q;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign pad_out_o = out_q;
    assign pad_oe_o = oe_q;
    assign analog_drive_o = adrv_q;
    assign notice_irq_o = irq_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // Clear alias only drops the written ones
    property p_dir_clr;
        (wr_dir_w && op_w == OP_CLR && wb_sel_i[1:0] == 2'h3)
            |=> dir_q == ($past(dir_q) & ~$past(wd_w));
    endproperty
    a_dir_clr: assert property (p_dir_clr) else $error("clr alias wrong");

    // Reset leaves all pins as analog inputs
    property p_reset_vals;
        @(posedge ref_clk_i) disable iff (1'b0)
        $past(sys_rst_i) |-> (dir_q == DIR_RST && ansel_q == ANALOG_RST);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

    // Pin address write lands in the latch
    property p_pin_write;
        (wr_w && base_w == REG_PIN && op_w == OP_WRITE && wb_sel_i[1:0] == 2'h3)
            |=> lat_q == $past(wd_w);
    endproperty
    a_pin_write: assert property (p_pin_write) else $error("latch not written");

    // Sampled pins equal the pads three clocks back
    property p_pin_delay;
        (!$past(sys_rst_i, 1) && !$past(sys_rst_i, 2) && !$past(sys_rst_i, 3))
            |-> pin_w == $past(pad_in_i, 3);
    endproperty
    a_pin_delay: assert property (p_pin_delay) else $error("pin delay wrong");

    // Open-drain pins never drive high
    property p_open_drain;
        1 |=> ((pad_out_o & $past(odc_q)) == ZERO_RST) && ((pad_oe_o & $past(dir_q)) == ZERO_RST);
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pad drive wrong");

    // Analog input pins read as zero
    property p_analog_zero;
        rd_pin_w |=> (wb_dat_o[15:0] & $past(ansel_q & dir_q)) == ZERO_RST;
    endproperty
    a_analog_zero: assert property (p_analog_zero) else $error("analog pin read high");

    // Flags hold unless software writes them
    property p_flag_hold;
        !wr_flags_w |=> (flags_q & $past(flags_q)) == $past(flags_q);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost");

    // No new flags while the module is off
    property p_off_quiet;
        (!ctrl_q[ON_BIT] && !wr_flags_w) |=> (flags_q & ~$past(flags_q)) == ZERO_RST;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("flag set while off");

    // Request follows the enabled input flags by one clock
    property p_irq;
        ##1 notice_irq_o == $past(ctrl_q[ON_BIT] && (|(flags_q & dir_q & (en_low_q | en_high_q))));
    endproperty
    a_irq: assert property (p_irq) else $error("request mismatch");

    // Main scenarios
    property p_cov_rise;
        chg.style && (|(chg.evt & en_low_q & ~en_high_q));
    endproperty
    c_cov_rise: cover property (p_cov_rise);
    property p_cov_mismatch;
        !chg.style && (|chg.evt);
    endproperty
    c_cov_mismatch: cover property (p_cov_mismatch);
    property p_cov_irq;
        $rose(notice_irq_o);
    endproperty
    c_cov_irq: cover property (p_cov_irq);

endmodule

// ===== testbench/gpc_pad_model.sv
// ------------------------------------------------------------
// Pad model
// ------------------------------------------------------------
module gpc_pad_model
    import gpc_pkg::*;
(
    input wire logic [PORT_W-1:0] pad_out_i,
    input wire logic [PORT_W-1:0] pad_oe_i,
    input wire logic [PORT_W-1:0] ext_i,
    output logic [PORT_W-1:0] level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // A driven pin shows the block's level; a released one the outside source
    assign level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
endmodule

// ===== testbench/gpc_port_top_test.sv
module gpc_port_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    import gpc_pkg::*;
    // ------------------------------------------------------------
    // Signals and model state
    // ------------------------------------------------------------
    logic ref_clk, sys_rst, cyc, stb, we, ack, irq;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat_w, dat_r;
    logic [PORT_W-1:0] ext, level, pad_out, pad_oe, ana_drv;
    int fail_count = 0;
    int checks_done = 0;
    int unsigned seed = 63;
    int m_reg [16]; // Register model indexed by adr[7:4]
    int m_ext; // Level the bench drives from outside
    int m_last; // Raw pin levels at the last pin read
    int regs [6] = '{0, 1, 2, 4, 6, 8};
    int rb [6] = '{0, 1, 3, 4, 6, 8}; // Pin writes land in the latch
    gpc_port_top gpc_port_top_i (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
        .wb_dat_o(dat_r), .wb_ack_o(ack), .pad_in_i(level), .pad_out_o(pad_out),
        .pad_oe_o(pad_oe), .analog_drive_o(ana_drv), .notice_irq_o(irq));
    gpc_pad_model gpc_pad_model_i (.pad_out_i(pad_out), .pad_oe_i(pad_oe), .ext_i(ext),
        .level_o(level));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Watchdog: whole run is well under this span
    initial begin
        #400000;
        fail_count++;
        report_and_stop();
    end
    function automatic int unsigned xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic report_and_stop();
        if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // ------------------------------------------------------------
    // Bus cycles: request held until ack is sampled high
    // ------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_w <= d;
        sel <= s;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) fail_count++;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input int d, input logic [3:0] s);
        int i, v, m;
        i = a[7:4];
        m = {{8{s[1]}}, {8{s[0]}}};
        v = d & m;
        bus(1'b1, a, d, s);
        if (i == 2) i = 3;
        if (i == 7 || i > 9) return; // Read-only and unmapped writes vanish
        case (a[3:2])
            2'h1: m_reg[i] &= ~v;
            2'h2: m_reg[i] |= v;
            2'h3: m_reg[i] ^= v;
            default: m_reg[i] = (m_reg[i] & ~m) | v;
        endcase
        if (i == 5) m_reg[i] &= NOTICE_CTRL_MASK;
    endtask
    task automatic rd(input logic [7:0] a);
        int i, e;
        i = a[7:4];
        e = (a[3:2] != 2'h0 || i > 9) ? 0 : m_reg[i];
        if (i == 2 && a[3:2] == 2'h0) begin
            e = m_ext & ~(m_reg[0] & m_reg[1]) & 16'hffff;
            // Mismatch reference keeps the raw pins, analog mask not applied
            m_last = m_ext & 16'hffff;
        end
        if (i == 7 && a[3:2] == 2'h0) e = m_ext ^ m_last;
        bus(1'b0, a, 32'h0, 4'hf);
        check("read data", dat_r, e);
    endtask
    task automatic pads();
        check("pad_out", pad_out, m_reg[3] & ~m_reg[4] & 16'hffff);
        check("pad_oe", pad_oe & ~m_reg[4], ~m_reg[1] & ~m_reg[4] & 16'hffff);
        check("od_high", pad_oe & pad_out & m_reg[4], 32'h0);
        check("analog_drive", ana_drv, m_reg[3] & ~m_reg[1] & m_reg[0]);
    endtask
    // One pin change, then flags and request against the model
    task automatic step(input int n);
        int p, ev, e;
        p = m_ext;
        ext <= 16'(n);
        m_ext = n;
        repeat (8) @(posedge ref_clk);
        if (m_reg[5][11]) ev = (m_reg[6] & ~p & n) | (m_reg[8] & p & ~n);
        else ev = m_reg[6] & (n ^ m_last);
        if (m_reg[5][15]) m_reg[9] |= ev & m_reg[1];
        rd(8'h90);
        e = m_reg[5][15] && (m_reg[9] & m_reg[1] & (m_reg[6] | m_reg[8])) != 0;
        check("irq", irq, e);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int i, r;
        {sys_rst, cyc, stb, we, adr, sel, dat_w, ext} = '0;
        sys_rst = 1'b1;
        m_reg = '{default: 0};
        m_reg[0] = 16'hffff;
        m_reg[1] = 16'hffff;
        m_ext = 0;
        m_last = 0;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        for (i = 0; i < 11; i++) rd(8'(i * 16));
        pads();
        for (i = 1; i < 4; i++) rd(8'(i * 4 + 16));
        // Every alias op on every plain register, random lanes
        for (i = 0; i < 60; i++) begin
            r = xs();
            wr(8'(regs[i % 6] * 16 + ((i / 6) % 4) * 4), r, 4'(r >> 16));
            rd(8'(rb[i % 6] * 16));
            pads();
        end
        wr(8'h70, 32'hffff, 4'h3);
        wr(8'ha0, 32'hffff, 4'h3);
        wr(8'h04, 32'hffff, 4'h3);
        wr(8'h18, 32'hffff, 4'h3);
        wr(8'h44, 32'hffff, 4'h3);
        wr(8'h20, r, 4'h3);
        pads();
        // Level change at the very edge of the read is not yet seen
        r = xs();
        ext <= 16'(r);
        m_ext = r & 16'hffff;
        repeat (6) @(posedge ref_clk);
        ext <= ~16'(r);
        rd(8'h20);
        m_ext = ~r & 16'hffff;
        repeat (4) @(posedge ref_clk);
        rd(8'h20);
        wr(8'h08, 32'h00ff, 4'h3);
        rd(8'h20);
        wr(8'h04, 32'hffff, 4'h3);
        // Change notice: rise on bit 0 and 3, fall on bit 1
        wr(8'h50, 32'h8800, 4'h3);
        wr(8'h60, 32'h0009, 4'h3);
        wr(8'h80, 32'h0002, 4'h3);
        step(0);
        wr(8'h94, 32'hffff, 4'h3);
        rd(8'h20);
        step(1);
        step(0);
        wr(8'h94, 32'h0001, 4'h3);
        step(2);
        step(0);
        wr(8'h54, 32'h0800, 4'h3);
        step(8);
        rd(8'h70);
        rd(8'h20);
        rd(8'h70);
        wr(8'h50, 32'h0, 4'h3);
        wr(8'h94, 32'hffff, 4'h3);
        step(1);
        step(0);
        wr(8'h50, 32'h8800, 4'h3);
        wr(8'h14, 32'h0001, 4'h3);
        wr(8'h48, 32'h0001, 4'h3);
        wr(8'h38, 32'h0001, 4'h3);
        pads();
        step(1);
        step(0);
        report_and_stop();
    end
endmodule
